// File: gcs_pkg.sv
/*
  constants, field positions and state codes of the gas detector
  calibration sequencer.
  assumes a single 40 mhz system clock and an axi4-lite register bus.
*/
// Contract
// - after replacement press, zero sensor input raises no fault
// - replacement mode disables the calibration timeout
// - routine calibration past 12 min aborts, restores, flashes red, logs
// - red led flashes for three seconds while reed is held
// - replacement: first reed sets zero, log position one, steady led
// - after zero, led flashes on rise; next reed captures span, steady
// - after span, wait below four percent, then complete and led off
// - replacement press during calibration restarts the replacement sequence
// - oxygen: flash, wait 3 s, capture span, steady, wait 3 s, off
// - infrared routine zero captured automatically when steady, led steady
// - span: flash on gas, capture after 30 s stable input
// - each good calibration logs zero, span and date stamp
// - aborted calibration logs zero and span as zero
// - log cleared only when replacement calibration succeeds
// - position one kept; beyond eight, overwrite oldest other than one
// - sensor is unsigned 12-bit counts, 0 is 0 ma, 4095 is 24 ma
// - oxygen replacement: after zero, led flashes when input goes high
// - timed out routine calibration flashes red and reverts values
package gcs_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned DB_CYC_DFLT = CLK_HZ / 1000 * DEBOUNCE_MS;

  // durations in seconds, timed against the seconds counter
  localparam logic [15:0] S_REED_START = 16'h0004;
  localparam logic [15:0] S_REED_ACT = 16'h0003;
  localparam logic [15:0] S_RED_FLASH = 16'h0003;
  localparam logic [15:0] S_REPL_HOLD = 16'h0001;
  localparam logic [15:0] S_ZERO_STEADY = 16'h0004;
  localparam logic [15:0] S_SPAN_STABLE = 16'h001E;
  localparam logic [15:0] S_O2_WAIT = 16'h0003;
  localparam logic [15:0] S_ABORT_FLASH = 16'h000A;
  localparam int unsigned TIMEOUT_MIN = 12;
  localparam logic [15:0] S_TIMEOUT = 16'(TIMEOUT_MIN * 60);

  // sensor scale
  localparam int unsigned ADC_W = 12;
  localparam int unsigned ADC_MAX = 4095;
  localparam int unsigned LOW_PCT = 4;
  localparam logic [11:0] LOW_CNT = 12'((ADC_MAX * LOW_PCT + 99) / 100);
  localparam logic [11:0] RISE_CNT = 12'h040;
  localparam logic [11:0] STABLE_TOL = 12'h008;
  localparam int unsigned LOG_N = 8;

  // register map
  localparam int unsigned AXI_AW = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAMP = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_CAL = 8'h0C;
  localparam logic [7:0] A_SENSOR = 8'h10;
  localparam logic [7:0] A_LOG = 8'h20;
  localparam logic [7:0] A_LOG_END = 8'h60;
  localparam int unsigned CAL_SPAN_LSB = 16;
  localparam int unsigned STAT_REPL = 4;
  localparam int unsigned STAT_CAL = 5;
  localparam int unsigned STAT_RED = 6;
  localparam int unsigned STAT_FAULT = 7;
  localparam int unsigned STAT_CNT_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    VAR_TOX = 2'b00,
    VAR_O2 = 2'b01,
    VAR_IR = 2'b10
  } gcs_var_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_RZ = 4'b0001,
    ST_RS = 4'b0010,
    ST_FALL = 4'b0011,
    ST_AZ = 4'b0100,
    ST_AS = 4'b0101,
    ST_O1 = 4'b0110,
    ST_O2 = 4'b0111
  } gcs_st_t;
endpackage

// File: gcs_switch_cond.sv
/*
  switch conditioner: two-flop synchroniser and a stable-level debouncer.
  assumes a raw mechanical or reed contact, active high.
*/
`timescale 1ns/1ps
`default_nettype none
module gcs_switch_cond import gcs_pkg::*; #(
  parameter int unsigned DB_CYC = DB_CYC_DFLT
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // contact
  input wire logic raw,
  output logic clean_ff
);
  localparam int unsigned CW = $clog2(DB_CYC + 1);
  logic meta_ff;
  logic sync_ff;
  logic [CW-1:0] cnt_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= raw;
      sync_ff <= meta_ff;
    end
  end

  // a level must hold for the whole window before it is believed
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      clean_ff <= 1'b0;
    end else if (sync_ff == clean_ff) begin
      cnt_ff <= '0;
    end else if (cnt_ff == CW'(DB_CYC - 1)) begin
      cnt_ff <= '0;
      clean_ff <= sync_ff;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end
endmodule
`default_nettype wire

// File: gcs_cal_seq.sv
/*
  calibration sequencer: switch timing, state machine, calibration
  values, calibration log and axi4-lite register slave.
  assumes sensor counts synchronous to sys_clk.
*/
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module gcs_cal_seq import gcs_pkg::*; #(
  parameter int unsigned SEC_CYC = CLK_HZ,
  parameter int unsigned DB_CYC = DB_CYC_DFLT
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // operator switches and sensor
  input wire logic reed_sw,
  input wire logic repl_sw,
  input wire logic [ADC_W-1:0] sensor_cnt,
  // indicators and applied calibration
  output logic cal_led_ff,
  output logic red_led_ff,
  output logic fault_ff,
  output logic [ADC_W-1:0] zero_cal_ff,
  output logic [ADC_W-1:0] span_cal_ff,
  // axi4-lite write
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int unsigned DW = $clog2(SEC_CYC);

  function automatic logic past_s(input logic [15:0] now,
                                  input logic [15:0] t0,
                                  input logic [15:0] n);
    return 16'(now - t0) > n;
  endfunction

  function automatic logic [11:0] adiff(input logic [11:0] a,
                                        input logic [11:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // 0: unmapped, 1: read only, 2: read and write
  function automatic logic [1:0] dec(input logic [7:0] a);
    if (a == A_CTRL || a == A_STAMP) return 2'd2;
    if (a == A_STATUS || a == A_CAL || a == A_SENSOR) return 2'd1;
    if (a >= A_LOG && a < A_LOG_END && a[1:0] == 2'b00) return 2'd1;
    return 2'd0;
  endfunction

  logic [DW-1:0] div_ff;
  logic [15:0] secs_ff;
  logic sec_tick, blink_ff;
  logic reed_db, repl_db, reed_q_ff, repl_q_ff, reed_done_ff, repl_done_ff;
  logic [15:0] reed_t0_ff, repl_t0_ff, stab_t0_ff, st_t0_ff, cal_t0_ff;
  logic [15:0] abort_t0_ff, reed_thr;
  logic reed_evt, repl_evt, tmo, gas, aborted_ff, repl_mode_ff;
  logic [11:0] ref_ff, prev_zero_ff, prev_span_ff, pend_z_ff, pend_s_ff;
  gcs_st_t st_ff, nxt_st;
  gcs_var_t var_ff;
  logic [31:0] stamp_ff;
  logic start, cap_zero, cap_span, done_ok, abort_evt, repl_start;
  logic commit_rt, commit_rp;
  logic [11:0] log_z_ff [LOG_N];
  logic [11:0] log_s_ff [LOG_N];
  logic [31:0] log_t_ff [LOG_N];
  logic [3:0] log_cnt_ff;
  logic [2:0] log_ptr_ff, log_idx;

  // seconds base and 1 hz flash
  assign sec_tick = (div_ff == DW'(SEC_CYC - 1));
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= '0;
      secs_ff <= 16'h0000;
      blink_ff <= 1'b0;
    end else begin
      div_ff <= sec_tick ? '0 : div_ff + DW'(1);
      if (sec_tick) secs_ff <= secs_ff + 16'h0001;
      if (sec_tick || div_ff == DW'(SEC_CYC / 2 - 1)) blink_ff <= !blink_ff;
    end
  end

  gcs_switch_cond #(.DB_CYC(DB_CYC)) u_reed (
    .sys_clk(sys_clk), .nrst(nrst), .raw(reed_sw), .clean_ff(reed_db));
  gcs_switch_cond #(.DB_CYC(DB_CYC)) u_repl (
    .sys_clk(sys_clk), .nrst(nrst), .raw(repl_sw), .clean_ff(repl_db));

  // hold times stamp the press and compare against the seconds counter
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reed_q_ff <= 1'b0;
      repl_q_ff <= 1'b0;
      reed_t0_ff <= 16'h0000;
      repl_t0_ff <= 16'h0000;
      reed_done_ff <= 1'b0;
      repl_done_ff <= 1'b0;
    end else begin
      reed_q_ff <= reed_db;
      repl_q_ff <= repl_db;
      if (reed_db && !reed_q_ff) reed_t0_ff <= secs_ff;
      if (repl_db && !repl_q_ff) repl_t0_ff <= secs_ff;
      reed_done_ff <= reed_db && (reed_done_ff || reed_evt);
      repl_done_ff <= repl_db && (repl_done_ff || repl_evt);
    end
  end

  // starting needs a longer hold than a capture step
  assign reed_thr = (st_ff == ST_IDLE) ? S_REED_START : S_REED_ACT;
  assign reed_evt = reed_db && reed_q_ff && !reed_done_ff &&
                    past_s(secs_ff, reed_t0_ff, reed_thr);
  assign repl_evt = repl_db && repl_q_ff && !repl_done_ff &&
                    past_s(secs_ff, repl_t0_ff, S_REPL_HOLD);

  // stability window restarts on any excursion or state change
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref_ff <= 12'h000;
      stab_t0_ff <= 16'h0000;
    end else if (st_ff != nxt_st ||
                 adiff(sensor_cnt, ref_ff) > STABLE_TOL) begin
      ref_ff <= sensor_cnt;
      stab_t0_ff <= secs_ff;
    end
  end

  assign gas = {1'b0, sensor_cnt} > ({1'b0, zero_cal_ff} + {1'b0, RISE_CNT});
  assign tmo = !repl_mode_ff && st_ff != ST_IDLE &&
               past_s(secs_ff, cal_t0_ff, S_TIMEOUT);

  always_comb begin
    nxt_st = st_ff;
    start = 1'b0;
    cap_zero = 1'b0;
    cap_span = 1'b0;
    done_ok = 1'b0;
    abort_evt = 1'b0;
    repl_start = 1'b0;
    if (repl_evt) begin
      repl_start = 1'b1;
      nxt_st = (var_ff == VAR_IR) ? ST_AZ : ST_RZ;
    end else if (tmo) begin
      abort_evt = 1'b1;
      nxt_st = ST_IDLE;
    end else begin
      unique case (st_ff)
        ST_IDLE: if (reed_evt) begin
          start = 1'b1;
          nxt_st = (var_ff == VAR_O2) ? ST_O1 : ST_AZ;
        end
        ST_RZ: if (reed_evt) begin
          cap_zero = 1'b1;
          nxt_st = ST_RS;
        end
        ST_RS: if (reed_evt) begin
          cap_span = 1'b1;
          done_ok = (var_ff == VAR_O2);
          nxt_st = (var_ff == VAR_O2) ? ST_IDLE : ST_FALL;
        end
        ST_FALL: if (sensor_cnt < LOW_CNT) begin
          done_ok = 1'b1;
          nxt_st = ST_IDLE;
        end
        ST_AZ: if (past_s(secs_ff, stab_t0_ff, S_ZERO_STEADY)) begin
          cap_zero = 1'b1;
          nxt_st = ST_AS;
        end
        ST_AS: if (gas && past_s(secs_ff, stab_t0_ff, S_SPAN_STABLE)) begin
          cap_span = 1'b1;
          nxt_st = ST_FALL;
        end
        ST_O1: if (past_s(secs_ff, st_t0_ff, S_O2_WAIT)) begin
          cap_span = 1'b1;
          nxt_st = ST_O2;
        end
        ST_O2: if (past_s(secs_ff, st_t0_ff, S_O2_WAIT)) begin
          done_ok = 1'b1;
          nxt_st = ST_IDLE;
        end
        default: nxt_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= ST_IDLE;
      st_t0_ff <= 16'h0000;
      cal_t0_ff <= 16'h0000;
      repl_mode_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (st_ff != nxt_st) st_t0_ff <= secs_ff;
      if (start) cal_t0_ff <= secs_ff;
      if (repl_start) repl_mode_ff <= 1'b1;
      else if (done_ok) repl_mode_ff <= 1'b0;
    end
  end

  // calibration values; previous pair kept for a timed-out revert
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      zero_cal_ff <= 12'h000;
      span_cal_ff <= 12'h000;
      prev_zero_ff <= 12'h000;
      prev_span_ff <= 12'h000;
      pend_z_ff <= 12'h000;
      pend_s_ff <= 12'h000;
    end else begin
      if (start) begin
        prev_zero_ff <= zero_cal_ff;
        prev_span_ff <= span_cal_ff;
        pend_z_ff <= zero_cal_ff;
      end
      if (cap_zero) begin
        zero_cal_ff <= sensor_cnt;
        pend_z_ff <= sensor_cnt;
      end
      if (cap_span) begin
        span_cal_ff <= sensor_cnt;
        pend_s_ff <= sensor_cnt;
      end
      if (abort_evt) begin
        zero_cal_ff <= prev_zero_ff;
        span_cal_ff <= prev_span_ff;
      end
    end
  end

  // indicators and fault
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aborted_ff <= 1'b0;
      abort_t0_ff <= 16'h0000;
      red_led_ff <= 1'b0;
      cal_led_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      if (abort_evt) begin
        aborted_ff <= 1'b1;
        abort_t0_ff <= secs_ff;
      end else if (start || repl_start ||
                   past_s(secs_ff, abort_t0_ff, S_ABORT_FLASH)) begin
        aborted_ff <= 1'b0;
      end
      red_led_ff <= blink_ff && (aborted_ff || (reed_db && reed_q_ff &&
                    16'(secs_ff - reed_t0_ff) < S_RED_FLASH));
      unique case (st_ff)
        ST_IDLE: cal_led_ff <= 1'b0;
        ST_RZ, ST_AZ, ST_O1: cal_led_ff <= blink_ff;
        ST_RS, ST_AS: cal_led_ff <= gas ? blink_ff : 1'b1;
        default: cal_led_ff <= 1'b1;
      endcase
      // a pulled sensor reads zero; not a fault while replacing
      fault_ff <= (sensor_cnt == 12'h000) && !repl_mode_ff;
    end
  end

  // calibration log, held in flops across the sequence
  assign commit_rt = (done_ok && !repl_mode_ff) || abort_evt;
  assign commit_rp = done_ok && repl_mode_ff;
  assign log_idx = (commit_rp || log_cnt_ff == 4'h0) ? 3'h0 : log_ptr_ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < LOG_N; i++) begin
        log_z_ff[i] <= 12'h000;
        log_s_ff[i] <= 12'h000;
        log_t_ff[i] <= 32'h0000_0000;
      end
      log_cnt_ff <= 4'h0;
      log_ptr_ff <= 3'h1;
    end else begin
      for (int i = 0; i < LOG_N; i++) begin
        if ((commit_rt || commit_rp) && log_idx == 3'(i)) begin
          log_z_ff[i] <= abort_evt ? 12'h000 : pend_z_ff;
          log_s_ff[i] <= abort_evt ? 12'h000 : pend_s_ff;
          log_t_ff[i] <= stamp_ff;
        end else if (commit_rp) begin
          log_z_ff[i] <= 12'h000;
          log_s_ff[i] <= 12'h000;
          log_t_ff[i] <= 32'h0000_0000;
        end
      end
      if (commit_rp) begin
        log_cnt_ff <= 4'h1;
        log_ptr_ff <= 3'h1;
      end else if (commit_rt) begin
        if (log_cnt_ff != 4'(LOG_N)) log_cnt_ff <= log_cnt_ff + 4'h1;
        if (log_cnt_ff != 4'h0) begin
          log_ptr_ff <= (log_ptr_ff == 3'(LOG_N - 1)) ? 3'h1 :
                        log_ptr_ff + 3'h1;
        end
      end
    end
  end

  // axi4-lite slave
  logic aw_ok_ff, w_ok_ff, do_wr;
  logic [7:0] awa_ff;
  logic [31:0] wd_ff, rd_word;
  logic [3:0] ws_ff;
  logic [1:0] rd_resp;
  logic [7:0] log_rd;

  assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_ok_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  // entries count from the log base, not from address zero
  assign log_rd = s_axi_araddr - A_LOG;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awa_ff <= 8'h00;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        awa_ff <= s_axi_awaddr;
      end else if (do_wr) aw_ok_ff <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wd_ff <= s_axi_wdata;
        ws_ff <= s_axi_wstrb;
      end else if (do_wr) w_ok_ff <= 1'b0;
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        unique case (dec(awa_ff))
          2'd2: s_axi_bresp <= RESP_OKAY;
          2'd1: s_axi_bresp <= RESP_SLVERR;
          default: s_axi_bresp <= RESP_DECERR;
        endcase
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // control and date stamp, written by software
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      var_ff <= VAR_TOX;
      stamp_ff <= 32'h0000_0000;
    end else if (do_wr) begin
      if (awa_ff == A_CTRL && ws_ff[0]) var_ff <= gcs_var_t'(wd_ff[1:0]);
      for (int b = 0; b < 4; b++) begin
        if (awa_ff == A_STAMP && ws_ff[b])
          stamp_ff[8*b +: 8] <= wd_ff[8*b +: 8];
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = (dec(s_axi_araddr) == 2'd0) ? RESP_DECERR : RESP_OKAY;
    if (s_axi_araddr == A_CTRL) rd_word[1:0] = var_ff;
    if (s_axi_araddr == A_STAMP) rd_word = stamp_ff;
    if (s_axi_araddr == A_STATUS) begin
      rd_word[3:0] = st_ff;
      rd_word[STAT_REPL] = repl_mode_ff;
      rd_word[STAT_CAL] = cal_led_ff;
      rd_word[STAT_RED] = red_led_ff;
      rd_word[STAT_FAULT] = fault_ff;
      rd_word[STAT_CNT_LSB +: 4] = log_cnt_ff;
    end
    if (s_axi_araddr == A_CAL) begin
      rd_word[11:0] = zero_cal_ff;
      rd_word[CAL_SPAN_LSB +: 12] = span_cal_ff;
    end
    if (s_axi_araddr == A_SENSOR) rd_word[11:0] = sensor_cnt;
    if (dec(s_axi_araddr) == 2'd1 && s_axi_araddr >= A_LOG) begin
      if (log_rd[2]) rd_word = log_t_ff[log_rd[5:3]];
      else begin
        rd_word[11:0] = log_z_ff[log_rd[5:3]];
        rd_word[CAL_SPAN_LSB +: 12] = log_s_ff[log_rd[5:3]];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence o2_span_step;
    st_ff == ST_O1 ##1 st_ff == ST_O2;
  endsequence

  chk_fault_masked: assert property (repl_mode_ff |=> !fault_ff)
    else $error("fault raised in replacement mode");
  chk_no_repl_tmo: assert property (repl_mode_ff |-> !abort_evt)
    else $error("timeout abort in replacement mode");
  chk_abort_restore: assert property (abort_evt |=>
    st_ff == ST_IDLE && zero_cal_ff == $past(prev_zero_ff) &&
    span_cal_ff == $past(prev_span_ff))
    else $error("abort did not restore values");
  chk_abort_late: assert property (abort_evt |->
    16'(secs_ff - cal_t0_ff) > S_TIMEOUT)
    else $error("abort before twelve minutes");
  chk_red_reed: assert property (reed_db && reed_q_ff && blink_ff &&
    16'(secs_ff - reed_t0_ff) < S_RED_FLASH |=> red_led_ff)
    else $error("red led not flashing during reed hold");
  chk_zero_capture: assert property (st_ff == ST_RZ &&
    reed_evt && !repl_evt |=>
    st_ff == ST_RS && zero_cal_ff == $past(sensor_cnt))
    else $error("replacement zero not captured");
  chk_fall_done: assert property (st_ff == ST_FALL &&
    sensor_cnt < LOW_CNT && !repl_evt && !tmo |=>
    st_ff == ST_IDLE ##1 !cal_led_ff)
    else $error("completion on low reading missed");
  chk_repl_restart: assert property (repl_evt |=> repl_mode_ff &&
    (st_ff == ST_RZ || st_ff == ST_AZ))
    else $error("replacement press did not restart");
  chk_o2_span: assert property (o2_span_step |->
    span_cal_ff == $past(sensor_cnt) && cal_t0_ff == $past(cal_t0_ff))
    else $error("oxygen span not captured");
  chk_span_stable: assert property (st_ff == ST_AS && cap_span |->
    16'(secs_ff - stab_t0_ff) > S_SPAN_STABLE && gas)
    else $error("span captured before stable window");
  chk_abort_zeros: assert property (abort_evt |=>
    log_z_ff[$past(log_idx)] == 12'h000 &&
    log_s_ff[$past(log_idx)] == 12'h000)
    else $error("aborted entry not zero");
  chk_keep_first: assert property (commit_rt && log_cnt_ff != 4'h0 |->
    log_idx != 3'h0)
    else $error("position one overwritten");
endmodule
`default_nettype wire

// File: gcs_operator.sv
/*
  operator model: reed magnet and replacement push switch.
  assumes gcs_cal_seq switch inputs, active high, and a visible red led.
*/
`timescale 1ns/1ps
`default_nettype none
module gcs_operator #(
  parameter int SEC = 20
) (
  // clock and indicator
  input wire logic sys_clk,
  input wire logic red_led,
  // switches
  output logic reed_sw,
  output logic repl_sw
);
  bit red_on;
  bit red_off;
  initial begin
    reed_sw = 1'b0;
    repl_sw = 1'b0;
  end
  // holds run in whole seconds; the device counts whole ticks
  task automatic hold(input bit repl, input int secs);
    red_on = 0;
    red_off = 0;
    @(posedge sys_clk);
    if (repl) repl_sw <= 1'b1;
    else reed_sw <= 1'b1;
    repeat (secs * SEC) begin
      @(posedge sys_clk);
      if (red_led) red_on = 1;
      else red_off = 1;
    end
    reed_sw <= 1'b0;
    repl_sw <= 1'b0;
    repeat (SEC) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// File: tb_gas_detector_calibration_sequencer.sv
/*
  bench for gcs_cal_seq: operator model, axi4-lite master, log model.
  assumes SEC_CYC and DB_CYC shortened so minutes fit the run.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_gas_detector_calibration_sequencer import gcs_pkg::*;;
  localparam int SEC = 20;
  logic sys_clk, nrst, reed_sw, repl_sw, cal_led_ff, red_led_ff, fault_ff;
  logic [11:0] sensor_cnt, zero_cal_ff, span_cal_ff;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] lg[$];
  int error_cnt, samples_checked, cyc, z, s, zz;
  gcs_cal_seq #(.SEC_CYC(SEC), .DB_CYC(4)) DUT (
    .sys_clk(sys_clk), .nrst(nrst), .reed_sw(reed_sw), .repl_sw(repl_sw),
    .sensor_cnt(sensor_cnt), .cal_led_ff(cal_led_ff),
    .red_led_ff(red_led_ff), .fault_ff(fault_ff),
    .zero_cal_ff(zero_cal_ff), .span_cal_ff(span_cal_ff),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  gcs_operator #(.SEC(SEC)) op (.sys_clk(sys_clk), .red_led(red_led_ff),
    .reed_sw(reed_sw), .repl_sw(repl_sw));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ceiling: two 12-minute waits plus margin
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      conclude;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("ERROR %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic sec(input int n);
    repeat (n * SEC) @(posedge sys_clk);
  endtask
  // flashing means both levels seen within one second
  task automatic seen(input string n, input bit red, input logic e);
    bit h;
    bit l;
    h = 0;
    l = 0;
    repeat (SEC) begin
      @(negedge sys_clk);
      if (red ? red_led_ff : cal_led_ff) h = 1;
      else l = 1;
    end
    @(posedge sys_clk);
    chk(n, {31'h0, e}, {31'h0, h & l});
  endtask
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    sensor_cnt = 12'h300;
    {error_cnt, samples_checked, cyc} = '0;
    void'($urandom(21655));
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    rdr(A_CAL);
    chk("cal reset", 32'h0000_0000, rd);
    wr(A_CTRL, 32'h0000_0000);
    chk("ctrl resp", RESP_OKAY, rsp);
    wr(A_STATUS, 32'h0000_0000);
    chk("status resp", RESP_SLVERR, rsp);
    rdr(8'hFC);
    chk("unmapped resp", RESP_DECERR, rsp);
    $display("test registers done");
    z = $urandom_range(12'h1FF, 12'h100);
    s = z + $urandom_range(12'h7FF, 12'h400);
    op.hold(1, 3);
    sensor_cnt <= 12'h000;
    sec(1);
    chk("fault", 32'h0000_0000, fault_ff);
    sec(725);
    rdr(A_STATUS);
    chk("repl no timeout", 32'h0000_0011, rd[4:0]);
    sensor_cnt <= 12'(z);
    op.hold(0, 5);
    chk("red flash", 32'h0000_0001, op.red_on & op.red_off);
    chk("zero", z, zero_cal_ff);
    seen("zero led", 0, 0);
    chk("zero steady", 32'h0000_0001, cal_led_ff);
    sensor_cnt <= 12'(s);
    sec(1);
    seen("rise led", 0, 1);
    op.hold(0, 5);
    chk("span", s, span_cal_ff);
    sensor_cnt <= 12'h050;
    sec(2);
    chk("done led", 32'h0000_0000, cal_led_ff);
    lg = {32'(s) << 16 | 32'(z)};
    $display("test replacement done");
    wr(A_CTRL, 32'h0000_0002);
    zz = z + 32;
    sensor_cnt <= 12'(zz);
    op.hold(0, 6);
    sec(6);
    chk("auto zero", zz, zero_cal_ff);
    while (zero_cal_ff !== 12'(z)) @(posedge sys_clk);
    chk("span back", s, span_cal_ff);
    seen("abort red", 1, 1);
    lg.push_back(32'h0000_0000);
    $display("test timeout done");
    wr(A_CTRL, 32'h0000_0001);
    s = $urandom_range(12'hEFF, 12'hA00);
    wr(A_STAMP, 32'(s));
    sensor_cnt <= 12'(s);
    op.hold(0, 6);
    while (span_cal_ff !== 12'(s)) @(posedge sys_clk);
    seen("o2 steady", 0, 0);
    chk("o2 on", 32'h0000_0001, cal_led_ff);
    sec(4);
    chk("o2 off", 32'h0000_0000, cal_led_ff);
    lg.push_back(32'(s) << 16 | 32'(z));
    foreach (lg[i]) begin
      rdr(8'(A_LOG + 8 * i));
      chk("log", lg[i], rd);
    end
    rdr(A_LOG + 8'h14);
    chk("stamp", s, rd);
    rdr(A_STATUS);
    chk("log count", lg.size(), rd[11:8]);
    $display("test oxygen done");
    wr(A_CTRL, 32'h0000_0000);
    sensor_cnt <= 12'(zz);
    op.hold(0, 6);
    sec(5);
    chk("rt zero", zz, zero_cal_ff);
    s = s - 256;
    sensor_cnt <= 12'(s);
    sec(1);
    seen("gas led", 0, 1);
    sec(30);
    chk("rt span", s, span_cal_ff);
    op.hold(1, 3);
    rdr(A_STATUS);
    chk("restart", 32'h0000_0011, rd[4:0]);
    $display("test restart done");
    conclude;
  end
endmodule
`default_nettype wire
